/* File: dsi_host_model.sv */
// Purpose: Video host model for headers, pixels and sync events
// Assumes: Signals change just after rising edges
// Notes:   Idle header fields show the inverted last value
`timescale 1ns/10ps
module dsi_host_model
(
   input  wire logic       clk,
   input  wire logic       slow,
   output logic            header_valid,
   output logic      [1:0] header_channel,
   output logic      [5:0] packet_type_code,
   output logic            pixel_en,
   output logic            hsync_event,
   output logic            vsync_event
);
   // ==========================================================
   // Pixel pacing
   initial
   begin
      header_valid = 1'b0;
      header_channel = 2'h0;
      packet_type_code = 6'h00;
      pixel_en = 1'b1;
      hsync_event = 1'b0;
      vsync_event = 1'b0;
   end
   always @(posedge clk) pixel_en <= slow ? !pixel_en : 1'b1;
   // ==========================================================
   // Packets and events
   task send_header(input logic [1:0] vc, input logic [5:0] t);
      @(posedge clk);
      header_valid <= 1'b1;
      header_channel <= vc;
      packet_type_code <= t;
      @(posedge clk);
      header_valid <= 1'b0;
      header_channel <= ~vc;
      packet_type_code <= ~t;
   endtask
   task sync_event(input logic vert);
      @(posedge clk);
      hsync_event <= !vert;
      vsync_event <= vert;
      @(posedge clk);
      hsync_event <= 1'b0;
      vsync_event <= 1'b0;
   endtask
endmodule // dsi_host_model

/* File: rx_regs_pkg.sv */
// Purpose: Shared constants for the receiver status and sync width bank
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes:   Offsets are byte addresses of the register port
package rx_regs_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFF_PACKET_IDENTITY = 8'h2a;
   localparam logic [7:0] OFF_ERR_PROTOCOL    = 8'h2b;
   localparam logic [7:0] OFF_ERR_PHY         = 8'h2c;
   localparam logic [7:0] OFF_ERR_COMMAND     = 8'h2d;
   localparam logic [7:0] OFF_HSW_HIGH        = 8'h30;
   localparam logic [7:0] OFF_HSW_LOW         = 8'h31;
   localparam logic [7:0] OFF_VSW_HIGH        = 8'h32;
   localparam logic [7:0] OFF_VSW_LOW         = 8'h33;
   localparam logic [7:0] OFF_SYNC_CONFIG     = 8'h40;
   localparam logic [7:0] OFF_ERR_ENABLE_0    = 8'h41;
   localparam logic [7:0] OFF_ERR_ENABLE_1    = 8'h42;
   localparam logic [7:0] OFF_ERR_STATUS      = 8'h43;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_HSW_LOW     = 8'h20;
   localparam logic [7:0] RST_VSW_LOW     = 8'h04;
   localparam logic [7:0] RST_ERR_ENABLE  = 8'hff;
   localparam logic [7:0] RST_SYNC_CONFIG = 8'h01;
   // ==========================================================
   // Field positions, pixel type range and error report masks
   localparam int VC_MSB          = 7;
   localparam int VC_LSB          = 6;
   localparam int TYPE_MSB        = 5;
   localparam int SYNC_PULSES_BIT = 0;
   localparam logic [3:0] PIXEL_TYPE_LO = 4'hb;
   localparam logic [3:0] PIXEL_TYPE_HI = 4'he;
   localparam logic [7:0] PROT_MASK  = 8'hbf;
   localparam logic [7:0] PHY_MASK   = 8'h7f;
   localparam logic [7:0] CMD_MASK   = 8'h07;
endpackage

/* File: rx_status_sync_regs.sv */
// Purpose: Receiver packet identity, error report and sync width bank
// Assumes: Protocol logic gives header strobes and error pulses
// Notes:   Reads answer one cycle after the read strobe
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module rx_status_sync_regs
#(
   parameter int WIDTH_BITS = 10
)
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   input  wire logic       header_valid,
   input  wire logic [1:0] header_channel,
   input  wire logic [5:0] packet_type_code,
   input  wire logic [7:0] protocol_errors,
   input  wire logic [7:0] phy_errors,
   input  wire logic [7:0] command_errors,
   input  wire logic       pixel_en,
   input  wire logic       hsync_event,
   input  wire logic       vsync_event,
   output logic            error_detected,
   output logic            hsync_gen,
   output logic            vsync_gen,
   output logic            hsync_pass,
   output logic            vsync_pass
);
   logic [7:0] identity_reg;
   logic [7:0] err_prot_reg;
   logic [7:0] err_phy_reg;
   logic [7:0] err_cmd_reg;
   logic [7:0] hsw_high_reg;
   logic [7:0] hsw_low_reg;
   logic [7:0] vsw_high_reg;
   logic [7:0] vsw_low_reg;
   logic [7:0] sync_cfg_reg;
   logic [7:0] err_en0_reg;
   logic [7:0] err_en1_reg;
   logic [7:0] rdata_next;
   logic       sync_events;
   logic       error_hit;
   logic       gen_h;
   logic       gen_v;
   logic [WIDTH_BITS-1:0] hsync_width;
   logic [WIDTH_BITS-1:0] vsync_width;

   // ==========================================================
   // Helpers
   function automatic logic is_pixel_type(input logic [5:0] code);
      is_pixel_type = (code[3:0] >= rx_regs_pkg::PIXEL_TYPE_LO)
                   && (code[3:0] <= rx_regs_pkg::PIXEL_TYPE_HI);
   endfunction

   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = reg_write && (reg_addr == off);
   endfunction

   // ==========================================================
   // Packet identity capture
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         identity_reg <= 8'h00;
      else if (header_valid && is_pixel_type(packet_type_code))
         identity_reg <= {header_channel, packet_type_code};
   end

   // ==========================================================
   // Error report registers follow live error status
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         err_prot_reg <= 8'h00;
         err_phy_reg  <= 8'h00;
         err_cmd_reg  <= 8'h00;
      end
      else
      begin
         err_prot_reg <= protocol_errors & rx_regs_pkg::PROT_MASK;
         err_phy_reg  <= phy_errors & rx_regs_pkg::PHY_MASK;
         err_cmd_reg  <= command_errors & rx_regs_pkg::CMD_MASK;
      end
   end

   // ==========================================================
   // Aggregate error status, gated by enables
   always_comb
   begin
      error_hit = 1'b0;
      // Enable 0: bit7 ecc1, bit4 lp sync, 3 timeout, 2 escape, 1 sot sync,
      // 0 sot
      error_hit = (err_en0_reg[7] && protocol_errors[0])
               || (err_en0_reg[4] && phy_errors[4])
               || (err_en0_reg[3] && phy_errors[5])
               || (err_en0_reg[2] && phy_errors[3])
               || (err_en0_reg[1] && phy_errors[1])
               || (err_en0_reg[0] && phy_errors[0])
               || (err_en1_reg[6] && phy_errors[2])
               || (err_en1_reg[5] && protocol_errors[7])
               || (err_en1_reg[4] && protocol_errors[5])
               || (err_en1_reg[3] && protocol_errors[4])
               || (err_en1_reg[2] && protocol_errors[3])
               || (err_en1_reg[1] && protocol_errors[2])
               || (err_en1_reg[0] && protocol_errors[1]);
   end

   // Sticky flag, cleared on read; a new error wins over the clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         error_detected <= 1'b0;
      else if (error_hit)
         error_detected <= 1'b1;
      else if (reg_read && reg_addr == rx_regs_pkg::OFF_ERR_STATUS)
         error_detected <= 1'b0;
   end

   // ==========================================================
   // Writable configuration
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hsw_high_reg <= 8'h00;
         hsw_low_reg  <= rx_regs_pkg::RST_HSW_LOW;
         vsw_high_reg <= 8'h00;
         vsw_low_reg  <= rx_regs_pkg::RST_VSW_LOW;
      end
      else
      begin
         if (wr_hit(rx_regs_pkg::OFF_HSW_HIGH))
            hsw_high_reg <= {6'h00, reg_wdata[1:0]};
         if (wr_hit(rx_regs_pkg::OFF_HSW_LOW))
            hsw_low_reg <= reg_wdata;
         if (wr_hit(rx_regs_pkg::OFF_VSW_HIGH))
            vsw_high_reg <= {6'h00, reg_wdata[1:0]};
         if (wr_hit(rx_regs_pkg::OFF_VSW_LOW))
            vsw_low_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_cfg_reg <= rx_regs_pkg::RST_SYNC_CONFIG;
         err_en0_reg  <= rx_regs_pkg::RST_ERR_ENABLE;
         err_en1_reg  <= {1'b0, rx_regs_pkg::RST_ERR_ENABLE[6:0]};
      end
      else
      begin
         if (wr_hit(rx_regs_pkg::OFF_SYNC_CONFIG))
            sync_cfg_reg <= {7'h00, reg_wdata[0]};
         if (wr_hit(rx_regs_pkg::OFF_ERR_ENABLE_0))
            err_en0_reg <= reg_wdata;
         if (wr_hit(rx_regs_pkg::OFF_ERR_ENABLE_1))
            err_en1_reg <= {1'b0, reg_wdata[6:0]};
      end
   end

   // ==========================================================
   // Read port
   always_comb
   begin
      case (reg_addr)
         rx_regs_pkg::OFF_PACKET_IDENTITY: rdata_next = identity_reg;
         rx_regs_pkg::OFF_ERR_PROTOCOL:    rdata_next = err_prot_reg;
         rx_regs_pkg::OFF_ERR_PHY:         rdata_next = err_phy_reg;
         rx_regs_pkg::OFF_ERR_COMMAND:     rdata_next = err_cmd_reg;
         rx_regs_pkg::OFF_HSW_HIGH:        rdata_next = hsw_high_reg;
         rx_regs_pkg::OFF_HSW_LOW:         rdata_next = hsw_low_reg;
         rx_regs_pkg::OFF_VSW_HIGH:        rdata_next = vsw_high_reg;
         rx_regs_pkg::OFF_VSW_LOW:         rdata_next = vsw_low_reg;
         rx_regs_pkg::OFF_SYNC_CONFIG:     rdata_next = sync_cfg_reg;
         rx_regs_pkg::OFF_ERR_ENABLE_0:    rdata_next = err_en0_reg;
         rx_regs_pkg::OFF_ERR_ENABLE_1:    rdata_next = err_en1_reg;
         rx_regs_pkg::OFF_ERR_STATUS:      rdata_next = {7'h00, error_detected};
         default:                          rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 8'h00;
      else if (reg_read)
         reg_rdata <= rdata_next;
      else
         reg_rdata <= 8'h00;
   end

   // ==========================================================
   // Sync generation
   assign sync_events = !sync_cfg_reg[rx_regs_pkg::SYNC_PULSES_BIT];
   assign hsync_width = {hsw_high_reg[1:0], hsw_low_reg};
   assign vsync_width = {vsw_high_reg[1:0], vsw_low_reg};

   sync_pulse_gen #(
      .WIDTH_BITS (WIDTH_BITS)
   ) u_gen (
      .clk         (clk),
      .resetn      (resetn),
      .pixel_en    (pixel_en),
      .hsync_event (hsync_event && sync_events),
      .vsync_event (vsync_event && sync_events),
      .hsync_width (hsync_width),
      .vsync_width (vsync_width),
      .hsync_out   (gen_h),
      .vsync_out   (gen_v)
   );

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hsync_gen  <= 1'b0;
         vsync_gen  <= 1'b0;
         hsync_pass <= 1'b0;
         vsync_pass <= 1'b0;
      end
      else
      begin
         hsync_gen  <= gen_h;
         vsync_gen  <= gen_v;
         hsync_pass <= hsync_event && !sync_events;
         vsync_pass <= vsync_event && !sync_events;
      end
   end
endmodule // rx_status_sync_regs

/* File: rx_status_sync_regs_asserts.sv */
// Purpose: Port checker for the status and sync width bank
// Assumes: Read data stand one cycle after the read strobe
// Notes:   Bound to every instance of the bank
`timescale 1ns/10ps
module rx_status_sync_regs_asserts
#(
   parameter int WIDTH_BITS = 10
)
(
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       header_valid,
   input wire logic [1:0] header_channel,
   input wire logic [5:0] packet_type_code,
   input wire logic [7:0] protocol_errors,
   input wire logic [7:0] phy_errors,
   input wire logic [7:0] command_errors,
   input wire logic       hsync_event,
   input wire logic       vsync_event,
   input wire logic       hsync_gen,
   input wire logic       vsync_gen,
   input wire logic       error_detected
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   packet_id_a: assert property (
      header_valid && packet_type_code[3:0] inside {[4'hb:4'he]} ##1
      reg_read && reg_addr == 8'h2a |=>
      reg_rdata == {$past(header_channel, 2), $past(packet_type_code, 2)})
      else $error("identity read mismatch");
   prot_report_a: assert property (
      reg_read && reg_addr == 8'h2b |=>
      reg_rdata == ($past(protocol_errors, 2) & 8'hbf))
      else $error("protocol report mismatch");
   phy_report_a: assert property (
      reg_read && reg_addr == 8'h2c |=>
      reg_rdata == ($past(phy_errors, 2) & 8'h7f))
      else $error("phy report mismatch");
   cmd_report_a: assert property (
      reg_read && reg_addr == 8'h2d |=>
      reg_rdata == ($past(command_errors, 2) & 8'h07))
      else $error("command report mismatch");
   hsync_cause_a: assert property (
      $rose(hsync_gen) |-> $past(hsync_event, 2) || $past(hsync_event, 3))
      else $error("hsync pulse without event");
   vsync_cause_a: assert property (
      $rose(vsync_gen) |-> $past(vsync_event, 2) || $past(vsync_event, 3))
      else $error("vsync pulse without event");
   err_raise_a: assert property (
      $rose(error_detected) |-> ($past(protocol_errors) & 8'hbf) != 8'h00
      || ($past(phy_errors) & 8'h3f) != 8'h00)
      else $error("error flag without enabled error");
   err_clear_a: assert property (
      reg_read && reg_addr == 8'h43 && (protocol_errors | phy_errors |
      $past(protocol_errors) | $past(phy_errors)) == 8'h00 |=> !error_detected)
      else $error("error flag not cleared by read");
   cover property (header_valid ##1 reg_read && reg_addr == 8'h2a);
   cover property ($rose(hsync_gen));
   cover property ($rose(vsync_gen));
endmodule // rx_status_sync_regs_asserts

bind rx_status_sync_regs rx_status_sync_regs_asserts
   #(.WIDTH_BITS(WIDTH_BITS)) i_rx_status_sync_regs_asserts
(
   .clk, .resetn, .reg_addr, .reg_read, .reg_rdata, .header_valid,
   .header_channel, .packet_type_code, .protocol_errors, .phy_errors,
   .command_errors, .hsync_event, .vsync_event, .hsync_gen, .vsync_gen,
   .error_detected
);

/* File: sync_pulse_gen.sv */
// Purpose: Sync pulse generator: hsync in pixels, vsync in lines
// Assumes: One pixel enable per pixel clock
// Notes:   Widths are sampled at pulse start
`timescale 1ns/10ps
module sync_pulse_gen
#(
   parameter int WIDTH_BITS = 10
)
(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  pixel_en,
   input  wire logic                  hsync_event,
   input  wire logic                  vsync_event,
   input  wire logic [WIDTH_BITS-1:0] hsync_width,
   input  wire logic [WIDTH_BITS-1:0] vsync_width,
   output logic                       hsync_out,
   output logic                       vsync_out
);
   logic [WIDTH_BITS-1:0] h_count_reg;
   logic [WIDTH_BITS-1:0] v_count_reg;
   logic                  h_end;

   assign h_end = hsync_out && pixel_en && (h_count_reg <= 1);

   // ==========================================================
   // Horizontal pulse, counted in pixel clocks
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hsync_out   <= 1'b0;
         h_count_reg <= '0;
      end
      else if (hsync_event && hsync_width != '0)
      begin
         hsync_out   <= 1'b1;
         h_count_reg <= hsync_width;
      end
      else if (hsync_out && pixel_en)
      begin
         h_count_reg <= h_count_reg - 1'b1;
         if (h_count_reg <= 1)
            hsync_out <= 1'b0;
      end
   end

   // ==========================================================
   // Vertical pulse, counted in hsync pulses
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         vsync_out   <= 1'b0;
         v_count_reg <= '0;
      end
      else if (vsync_event && vsync_width != '0)
      begin
         vsync_out   <= 1'b1;
         v_count_reg <= vsync_width;
      end
      else if (vsync_out && h_end)
      begin
         v_count_reg <= v_count_reg - 1'b1;
         if (v_count_reg <= 1)
            vsync_out <= 1'b0;
      end
   end
endmodule // sync_pulse_gen

/* File: testbench.sv */
// Purpose: Self-checking bench for the status and sync width bank
// Assumes: 20 MHz clock, reset held three cycles
// Notes:   Host model drives headers, pixels and sync events
`timescale 1ns/10ps
module testbench;
   // ==========================================================
   // Signals
   logic       clk = 1'b0;
   logic       resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] protocol_errors = 8'h00;
   logic [7:0] phy_errors = 8'h00;
   logic [7:0] command_errors = 8'h00;
   logic       pixel_slow = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] header_channel;
   logic [5:0] packet_type_code;
   logic       header_valid, pixel_en, hsync_event, vsync_event;
   logic       error_detected, hsync_gen, vsync_gen, hsync_pass, vsync_pass;
   int         fails = 0;
   int         check_count = 0;
   always #25 clk = !clk;
   rx_status_sync_regs #(.WIDTH_BITS(10)) i_rx_status_sync_regs
   (
      .clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .header_valid, .header_channel, .packet_type_code, .protocol_errors,
      .phy_errors, .command_errors, .pixel_en, .hsync_event, .vsync_event,
      .error_detected, .hsync_gen, .vsync_gen, .hsync_pass, .vsync_pass
   );
   dsi_host_model i_dsi_host_model
   (
      .clk, .slow(pixel_slow), .header_valid, .header_channel,
      .packet_type_code, .pixel_en,
      .hsync_event, .vsync_event
   );
   // ==========================================================
   // Bus and compare tasks
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(n, {8'h00, e}, {8'h00, reg_rdata});
   endtask
   task count_hi(input int lim, output int hn);
      hn = 0;
      repeat (lim)
      begin
         @(posedge clk);
         #1;
         hn += int'(hsync_gen === 1'b1);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task t_map;
      logic [7:0] ra [9];
      logic [7:0] rv [9];
      ra = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h30, 8'h31, 8'h32, 8'h33, 8'h50};
      rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h04, 8'h00};
      for (int i = 0; i < 9; i++)
         rd(ra[i], rv[i], "reset value");
      wr(8'h2a, 8'hff);
      rd(8'h2a, 8'h00, "read-only identity");
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h03, "hsync width high");
      wr(8'h32, 8'hff);
      rd(8'h32, 8'h03, "vsync width high");
   endtask
   task t_capture;
      logic [7:0] exp;
      exp = 8'h00;
      for (int n = 10; n < 16; n++)
      begin
         i_dsi_host_model.send_header(2'(n), {2'b10, 4'(n)});
         if (n > 10 && n < 15)
            exp = {2'(n), 2'b10, 4'(n)};
         reg_read <= 1'b1;
         reg_addr <= 8'h2a;
         @(posedge clk);
         reg_read <= 1'b0;
         #1;
         chk("identity", 16'(exp), 16'(reg_rdata));
      end
   endtask
   task t_errors;
      @(posedge clk);
      protocol_errors <= 8'hff;
      phy_errors <= 8'hff;
      command_errors <= 8'hff;
      repeat (3) @(posedge clk);
      #1;
      chk("error flag", 16'h0001, {15'h0, error_detected});
      rd(8'h2b, 8'hbf, "protocol report");
      rd(8'h2c, 8'h7f, "phy report");
      rd(8'h2d, 8'h07, "command report");
      @(posedge clk);
      protocol_errors <= 8'h00;
      phy_errors <= 8'h00;
      command_errors <= 8'h00;
      repeat (2) @(posedge clk);
      rd(8'h43, 8'h01, "error status");
      chk("error cleared", 16'h0000, {15'h0, error_detected});
      wr(8'h41, 8'h00);
      wr(8'h42, 8'h00);
      protocol_errors <= 8'hbf;
      phy_errors <= 8'h7f;
      repeat (3) @(posedge clk);
      #1;
      chk("masked error", 16'h0000, {15'h0, error_detected});
      @(posedge clk);
      protocol_errors <= 8'h00;
      phy_errors <= 8'h00;
   endtask
   task t_pass;
      int hn;
      i_dsi_host_model.sync_event(1'b0);
      #1;
      chk("hsync pass", 16'h0001, {15'h0, hsync_pass});
      count_hi(10, hn);
      chk("gen in pulse mode", 16'h0000, 16'(hn));
      i_dsi_host_model.sync_event(1'b1);
      #1;
      chk("vsync pass", 16'h0001, {15'h0, vsync_pass});
   endtask
   task t_hsync;
      int hn;
      wr(8'h40, 8'h00);
      wr(8'h30, 8'h01);
      wr(8'h31, 8'h03);
      i_dsi_host_model.sync_event(1'b0);
      count_hi(300, hn);
      chk("hsync width", 16'h0103, 16'(hn));
   endtask
   task t_vsync;
      int hn;
      wr(8'h32, 8'h00);
      wr(8'h33, 8'h02);
      wr(8'h30, 8'h00);
      wr(8'h31, 8'h04);
      pixel_slow <= 1'b1;
      i_dsi_host_model.sync_event(1'b1);
      i_dsi_host_model.sync_event(1'b0);
      count_hi(14, hn);
      chk("vsync after one line", 16'h0001, {15'h0, vsync_gen});
      i_dsi_host_model.sync_event(1'b0);
      count_hi(14, hn);
      chk("vsync after two lines", 16'h0000, {15'h0, vsync_gen});
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      t_map();
      t_capture();
      t_errors();
      t_pass();
      t_hsync();
      t_vsync();
      test_done();
   end
endmodule // testbench
